// ### pkg/timer16_consts.vh
// How it works
// - Operating-mode field 10 selects clear-and-start on primary edges.
// - Pin edges count only after two equal consecutive samples.
// - In clear-and-start, the counter clears on the same edge as a primary capture.
// - Reverse-phase capture: clear on selected edge, capture A on opposite edge.
// - Edge-toggle option inverts output on primary valid edges, including the clear.
// - Reverse-phase capture into register A raises no irq_a.
// - Secondary valid edges still raise irq_a during reverse-phase capture.
// - Secondary edge during reverse-phase capture: irq_a, no capture.
// - Register A compare match raises irq_a, counter not cleared.
// - Register B compare match raises irq_b, counter not cleared.
// - Register A captures on primary reverse or secondary edge as set.
// - Register B captures only on primary valid edges.
// - Clear-and-start, both capturing: primary edge captures B, clears, toggles with option.
// - Output-control field 11 inverts output on either compare match.
// - Operating-mode field 01 runs free, no clearing on matches.
// - After FFFFH the counter wraps to 0000H and sets overflow.
// - Free-running compares: each match toggles output, raises its irq.
// - Free-running B capture: primary edge captures B, raises irq_b.
// - Free-running both capturing: toggle only on primary edges with option.
// - Free-running both capturing: B on primary, A on secondary edges.
// - Secondary-only edges never load register B.
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH
`define OFS_MODE    8'h00
`define OFS_CAPT    8'h04
`define OFS_OUTC    8'h08
`define OFS_PRES    8'h0C
`define OFS_COUNT   8'h10
`define OFS_CCA     8'h14
`define OFS_CCB     8'h18
`define MODE_OVF    0
`define MODE_ETOG   1
`define MODE_OP_LO  2
`define MODE_OP_HI  3
`define MODE_OUT_LO 4
`define MODE_OUT_HI 5
`define OP_STOP     2'b00
`define OP_FREE     2'b01
`define OP_CLEAR    2'b10
`define OUT_MATCH   2'b11
`define CAPT_A_CAP  0
`define CAPT_REV    1
`define CAPT_B_CAP  2
`define OUTC_EN     0
`define PRES_CLK_LO 0
`define PRES_CLK_HI 1
`define PRES_PRI_LO 3
`define PRES_PRI_HI 4
`define PRES_SEC_LO 5
`define PRES_SEC_HI 6
`define EDGE_FALL   2'b00
`define EDGE_RISE   2'b01
`define EDGE_NONE   2'b10
`define EDGE_BOTH   2'b11
`define RST_BYTE    8'h00
`define CNT_ZERO    16'h0000
`define CNT_MAX     16'hFFFF
`define RD_ZERO     32'h0000_0000
`endif

// ### rtl/count_prescaler.v
`timescale 1ns/1ps
`include "timer16_consts.vh"
module count_prescaler #(
  parameter DIV_W = 6
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       run,
  input  wire [1:0] sel,
  output wire       tick
);
  reg  [DIV_W-1:0] div_reg;
  wire [DIV_W-1:0] mask;

  // Division ratios are 1, 4, 16 and 64 system clocks.
  assign mask = ~({DIV_W{1'b1}} << {sel, 1'b0});
  assign tick = run & ((div_reg & mask) == mask);

  // The divider restarts whenever counting stops, so the first count
  // clock after a start always comes a full period later.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= {DIV_W{1'b0}};
    end else if (!run) begin
      div_reg <= {DIV_W{1'b0}};
    end else begin
      div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ### rtl/edge_qualifier.v
`timescale 1ns/1ps
`include "timer16_consts.vh"
module edge_qualifier (
  input  wire clk_sys,
  input  wire rst,
  input  wire pin,
  output reg  rise,
  output reg  fall
);
  reg samp_a_reg;
  reg samp_b_reg;
  reg level_reg;

  // A new level is taken only when two samples in a row agree, so
  // a one-cycle glitch never becomes an edge.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      samp_a_reg <= 1'b0;
      samp_b_reg <= 1'b0;
      level_reg  <= 1'b0;
      rise       <= 1'b0;
      fall       <= 1'b0;
    end else begin
      samp_a_reg <= pin;
      samp_b_reg <= samp_a_reg;
      rise       <= 1'b0;
      fall       <= 1'b0;
      if (samp_a_reg == samp_b_reg && samp_b_reg != level_reg) begin
        level_reg <= samp_b_reg;
        rise      <= samp_b_reg;
        fall      <= ~samp_b_reg;
      end
    end
  end
endmodule

// ### rtl/timer16_cc.v
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "timer16_consts.vh"
module timer16_cc #(
  parameter CNT_W = 16
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        primary_edge_input,
  input  wire        secondary_edge_input,
  output wire        toggle_output,
  output wire        irq_a,
  output wire        irq_b
);

  ////////////////////////////////////////////////////////////////////
  // Storage.

  reg  [7:0]       mode_control_reg;
  reg  [7:0]       capture_control_reg;
  reg  [7:0]       output_control_reg;
  reg  [7:0]       prescaler_reg;
  reg  [CNT_W-1:0] up_counter_reg;
  reg  [CNT_W-1:0] cc_register_a_reg;
  reg  [CNT_W-1:0] cc_register_b_reg;
  reg              toggle_reg;
  reg              irq_a_reg;
  reg              irq_b_reg;
  reg              tick_d_reg;
  reg              ack_reg;
  reg  [31:0]      dat_reg;
  reg  [31:0]      rd_data;

  reg  [CNT_W-1:0] up_counter_next;
  reg  [7:0]       mode_control_next;

  ////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // True when the selected edge of a pin has been seen.
  function edge_hit;
    input [1:0] sel;
    input       r;
    input       f;
    begin
      case (sel)
        `EDGE_FALL: edge_hit = f;
        `EDGE_RISE: edge_hit = r;
        `EDGE_BOTH: edge_hit = r | f;
        default:    edge_hit = 1'b0;
      endcase
    end
  endfunction

  // True on the phase opposite to the selected edge.
  function edge_rev;
    input [1:0] sel;
    input       r;
    input       f;
    begin
      case (sel)
        `EDGE_FALL: edge_rev = r;
        `EDGE_RISE: edge_rev = f;
        `EDGE_BOTH: edge_rev = r | f;
        default:    edge_rev = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Field views.

  wire [1:0] op_mode;
  wire [1:0] out_ctrl;
  wire [1:0] pri_sel;
  wire [1:0] sec_sel;
  wire [1:0] clk_sel;
  wire       edge_toggle_option;
  wire       overflow_flag;
  wire       a_is_capture;
  wire       b_is_capture;
  wire       reverse_phase_capture_sel;
  wire       out_enable;

  assign op_mode  = mode_control_reg[`MODE_OP_HI:`MODE_OP_LO];
  assign out_ctrl = mode_control_reg[`MODE_OUT_HI:`MODE_OUT_LO];
  assign pri_sel  = prescaler_reg[`PRES_PRI_HI:`PRES_PRI_LO];
  assign sec_sel  = prescaler_reg[`PRES_SEC_HI:`PRES_SEC_LO];
  assign clk_sel  = prescaler_reg[`PRES_CLK_HI:`PRES_CLK_LO];
  assign edge_toggle_option        = mode_control_reg[`MODE_ETOG];
  assign overflow_flag             = mode_control_reg[`MODE_OVF];
  assign a_is_capture              = capture_control_reg[`CAPT_A_CAP];
  assign b_is_capture              = capture_control_reg[`CAPT_B_CAP];
  assign reverse_phase_capture_sel = capture_control_reg[`CAPT_REV];
  assign out_enable                = output_control_reg[`OUTC_EN];

  ////////////////////////////////////////////////////////////////////
  // Pin qualification and count clock.

  wire pri_rise;
  wire pri_fall;
  wire sec_rise;
  wire sec_fall;
  wire tick;
  wire run;
  wire clear_mode;

  // Modes 00 and 11 hold the counter at zero; only 01 and 10 count.
  assign clear_mode = (op_mode == `OP_CLEAR);
  assign run = clear_mode | (op_mode == `OP_FREE);

  edge_qualifier pri_qual (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (primary_edge_input),
    .rise    (pri_rise),
    .fall    (pri_fall)
  );

  edge_qualifier sec_qual (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (secondary_edge_input),
    .rise    (sec_rise),
    .fall    (sec_fall)
  );

  count_prescaler #(
    .DIV_W (6)
  ) divider (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (run),
    .sel     (clk_sel),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Event decode.

  wire pri_valid;
  wire pri_rev;
  wire sec_valid;
  wire match_a;
  wire match_b;
  wire cap_a;
  wire cap_b;
  wire pri_clear;
  wire wrap;
  wire toggle_ev;
  wire irq_a_ev;
  wire irq_b_ev;

  assign pri_valid = run & edge_hit(pri_sel, pri_rise, pri_fall);
  assign pri_rev   = run & edge_rev(pri_sel, pri_rise, pri_fall);
  assign sec_valid = run & edge_hit(sec_sel, sec_rise, sec_fall);

  // Matches are judged one cycle after a count step, on the new value,
  // so a value is matched once per count clock and never while idle.
  assign match_a = tick_d_reg & ~a_is_capture &
                   (up_counter_reg == cc_register_a_reg);
  assign match_b = tick_d_reg & ~b_is_capture &
                   (up_counter_reg == cc_register_b_reg);

  // Register A: secondary edge, or the primary reverse phase.
  assign cap_a = a_is_capture &
                 (reverse_phase_capture_sel ? pri_rev :
                  sec_valid);

  // Register B listens to the primary pin alone.
  assign cap_b = b_is_capture & pri_valid;

  // A reverse-phase capture is silent, but a secondary edge still
  // interrupts; the capture itself is suppressed in that setting.
  assign irq_a_ev = match_a |
                    (a_is_capture & sec_valid);
  assign irq_b_ev = match_b | cap_b;

  assign pri_clear = clear_mode & pri_valid;
  assign wrap = run & tick & ~pri_clear &
                (up_counter_reg == `CNT_MAX);

  // Inversion on matches needs field 11; on primary edges it needs
  // the edge-toggle option, which covers the clear in mode 10.
  assign toggle_ev = (((match_a | match_b) &
                       (out_ctrl == `OUT_MATCH)) |
                      (edge_toggle_option & pri_valid)) &
                     out_enable;

  ////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire req;
  wire wr;
  wire lane0;
  wire lane1;

  // A write lands at the edge where the bus sees ack high.
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr    = req & wb_we_i & ack_reg;
  assign lane0 = wr & wb_sel_i[0];
  assign lane1 = wr & wb_sel_i[1];

  ////////////////////////////////////////////////////////////////////
  // Counter next value.

  // A clear from the primary pin beats a count step in the same cycle.
  always @* begin
    up_counter_next = up_counter_reg;
    if (!run) begin
      up_counter_next = `CNT_ZERO;
    end else if (pri_clear) begin
      up_counter_next = `CNT_ZERO;
    end else if (tick) begin
      up_counter_next = up_counter_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode control next value.

  // Software may only clear the overflow bit; a wrap in the same
  // cycle as that clear still leaves it set.
  always @* begin
    mode_control_next = mode_control_reg;
    if (lane0 && wb_adr_i == `OFS_MODE) begin
      mode_control_next[7:1] = wb_dat_i[7:1];
      mode_control_next[`MODE_OVF] = overflow_flag &
                                     wb_dat_i[`MODE_OVF];
    end
    if (wrap) begin
      mode_control_next[`MODE_OVF] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers.

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_control_reg    <= `RST_BYTE;
      capture_control_reg <= `RST_BYTE;
      output_control_reg  <= `RST_BYTE;
      prescaler_reg       <= `RST_BYTE;
    end else begin
      mode_control_reg <= mode_control_next;
      if (lane0 && wb_adr_i == `OFS_CAPT) begin
        capture_control_reg <= wb_dat_i[7:0];
      end
      if (lane0 && wb_adr_i == `OFS_OUTC) begin
        output_control_reg <= wb_dat_i[7:0];
      end
      if (lane0 && wb_adr_i == `OFS_PRES) begin
        prescaler_reg <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counter and capture/compare registers.

  // A capture beats a software write to the same register.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      up_counter_reg    <= `CNT_ZERO;
      cc_register_a_reg <= `CNT_ZERO;
      cc_register_b_reg <= `CNT_ZERO;
      tick_d_reg        <= 1'b0;
    end else begin
      up_counter_reg <= up_counter_next;
      tick_d_reg     <= run & tick & ~pri_clear;
      if (cap_a) begin
        cc_register_a_reg <= up_counter_reg;
      end else if (wb_adr_i == `OFS_CCA) begin
        if (lane0) begin
          cc_register_a_reg[7:0] <= wb_dat_i[7:0];
        end
        if (lane1) begin
          cc_register_a_reg[15:8] <= wb_dat_i[15:8];
        end
      end
      if (cap_b) begin
        cc_register_b_reg <= up_counter_reg;
      end else if (wb_adr_i == `OFS_CCB) begin
        if (lane0) begin
          cc_register_b_reg[7:0] <= wb_dat_i[7:0];
        end
        if (lane1) begin
          cc_register_b_reg[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output and interrupt pulses.

  // Disabling the output also forces it low, so a later enable
  // always starts from a known level.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      toggle_reg <= 1'b0;
      irq_a_reg  <= 1'b0;
      irq_b_reg  <= 1'b0;
    end else begin
      irq_a_reg <= irq_a_ev;
      irq_b_reg <= irq_b_ev;
      if (!out_enable) begin
        toggle_reg <= 1'b0;
      end else if (toggle_ev) begin
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  assign toggle_output = toggle_reg;
  assign irq_a         = irq_a_reg;
  assign irq_b         = irq_b_reg;

  ////////////////////////////////////////////////////////////////////
  // Read mux.

  // Unmapped addresses read as zero and still acknowledge.
  always @* begin
    rd_data = `RD_ZERO;
    case (wb_adr_i)
      `OFS_MODE:  rd_data[7:0]  = mode_control_reg;
      `OFS_CAPT:  rd_data[7:0]  = capture_control_reg;
      `OFS_OUTC:  rd_data[7:0]  = output_control_reg;
      `OFS_PRES:  rd_data[7:0]  = prescaler_reg;
      `OFS_COUNT: rd_data[15:0] = up_counter_reg;
      `OFS_CCA:   rd_data[15:0] = cc_register_a_reg;
      `OFS_CCB:   rd_data[15:0] = cc_register_b_reg;
      default:    rd_data = `RD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Wishbone acknowledge.

  // Read data is caught with the request and held while ack stands,
  // so the counter can move without tearing the returned word.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= `RD_ZERO;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) begin
        dat_reg <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule

// ### testbench/pin_source.sv
`timescale 1ns/1ps
module pin_source (
  input  wire clk_sys,
  output reg  pri_pin,
  output reg  sec_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // Both pins idle low; the source never looks at the timer output.
  initial begin
    pri_pin = 1'b0;
    sec_pin = 1'b0;
  end

  // Levels move just after a rising edge, like a synchronous source.
  task set_pin(input reg which, input reg v);
    begin
      @(posedge clk_sys);
      if (which)
        sec_pin <= v;
      else
        pri_pin <= v;
    end
  endtask

  // A high pulse of w cycles, used to probe the noise filter.
  task pulse(input reg which, input integer w);
    begin
      set_pin(which, 1'b1);
      repeat (w - 1) @(posedge clk_sys);
      set_pin(which, 1'b0);
    end
  endtask
endmodule

// ### testbench/timer16_cc_properties.sv
`timescale 1ns/1ps
module timer16_cc_properties #(
  parameter CNT_W = 16
) (
  input wire        clk_sys,
  input wire        rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        primary_edge_input,
  input wire        secondary_edge_input,
  input wire        toggle_output,
  input wire        irq_a,
  input wire        irq_b
);
  reg  [7:0] mode_shadow_reg;
  wire       stopped;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the mode byte; only its operating field is used, so the
  // hardware-owned overflow bit may differ from the copy without harm.
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      mode_shadow_reg <= 8'h00;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
             && wb_adr_i == 8'h00)
      mode_shadow_reg <= wb_dat_i[7:0];
  end
  assign stopped = (mode_shadow_reg[3] == mode_shadow_reg[2]);

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing, read data shape and event pulses.
  AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high for more than one cycle");
  AST_ACK_NEXT: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow a request by one cycle");
  AST_ACK_ONLY_ON_REQ: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  AST_READ_HIGH_ZERO: assert property
    (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_UNMAPPED_ZERO: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_IRQA_PULSE: assert property (irq_a |=> !irq_a)
    else $error("irq_a longer than one cycle");
  AST_IRQB_PULSE: assert property (irq_b |=> !irq_b)
    else $error("irq_b longer than one cycle");
  AST_STOPPED_QUIET: assert property
    (stopped && $past(stopped) && $past(stopped, 2) |-> !irq_a && !irq_b)
    else $error("interrupt while the counter is stopped");

  COV_IRQ_A: cover property (irq_a);
  COV_IRQ_B: cover property (irq_b);
  COV_TOGGLE: cover property ($changed(toggle_output));
endmodule

bind timer16_cc timer16_cc_properties #(.CNT_W(CNT_W)) chk_i (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .primary_edge_input(primary_edge_input),
  .secondary_edge_input(secondary_edge_input),
  .toggle_output(toggle_output), .irq_a(irq_a), .irq_b(irq_b));

// ### testbench/timer16_cc_tb.sv
`timescale 1ns/1ps
`include "timer16_consts.vh"
module timer16_cc_tb;
  reg         clk_sys;
  reg         rst;
  reg         wb_cyc_i;
  reg         wb_stb_i;
  reg         wb_we_i;
  reg  [7:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        pri;
  wire        sec;
  wire        toggle_output;
  wire        irq_a;
  wire        irq_b;
  reg  [31:0] q;
  reg  [31:0] v;
  integer     err_count;
  integer     samples_checked;
  integer     na;
  integer     nb;
  integer     nt;

  timer16_cc uut (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .primary_edge_input(pri), .secondary_edge_input(sec),
    .toggle_output(toggle_output), .irq_a(irq_a), .irq_b(irq_b));
  pin_source src (.clk_sys(clk_sys), .pri_pin(pri), .sec_pin(sec));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock.
  always #2 clk_sys = ~clk_sys;

  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task bus(input reg w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (wb_ack_o !== 1'b1)
        chk("bus_ack", 32'h0000_0001, 32'h0000_0000);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask

  // Counts pulses and output flips, sampled mid-cycle where all is settled.
  task watch(input integer n);
    integer i;
    reg     pt;
    begin
      na = 0;
      nb = 0;
      nt = 0;
      @(negedge clk_sys);
      pt = toggle_output;
      for (i = 0; i < n; i = i + 1) begin
        @(negedge clk_sys);
        if (irq_a === 1'b1) na = na + 1;
        if (irq_b === 1'b1) nb = nb + 1;
        if (toggle_output !== pt) nt = nt + 1;
        pt = toggle_output;
      end
    end
  endtask

  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task t_reset;
    integer   i;
    reg [7:0] a;
    begin
      a = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        bus(1'b0, a, 32'h0000_0000);
        chk("reset_value", 32'h0000_0000, q);
        a = a + 8'h04;
      end
      bus(1'b1, 8'h1C, 32'h0000_FFFF);
      bus(1'b0, 8'h1C, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, q);
      bus(1'b1, `OFS_OUTC, 32'h0000_0001);
      $display("test reset done");
    end
  endtask

  task t_free_cmp;
    begin
      bus(1'b1, `OFS_CCA, 32'h0000_0005);
      bus(1'b1, `OFS_CCB, 32'h0000_0009);
      bus(1'b1, `OFS_PRES, 32'h0000_0050);
      bus(1'b1, `OFS_MODE, 32'h0000_0034);
      watch(30);
      chk("cmp_irq_a", 32'h0000_0001, na);
      chk("cmp_irq_b", 32'h0000_0001, nb);
      chk("cmp_toggles", 32'h0000_0002, nt);
      bus(1'b0, `OFS_COUNT, 32'h0000_0000);
      chk("count_kept", 32'h0000_0001, q > 32'h0000_0009);
      bus(1'b1, `OFS_MODE, 32'h0000_0000);
      $display("test free compare done");
    end
  endtask

  task t_ovf;
    integer n;
    begin
      bus(1'b1, `OFS_MODE, 32'h0000_0004);
      n = 0;
      q = 32'h0000_0000;
      while (q[0] !== 1'b1 && n < 24000) begin
        bus(1'b0, `OFS_MODE, 32'h0000_0000);
        n = n + 1;
      end
      chk("ovf_seen", 32'h0000_0001, n < 24000);
      bus(1'b0, `OFS_COUNT, 32'h0000_0000);
      chk("count_wrapped", 32'h0000_0001, q < 32'h0000_0040);
      bus(1'b1, `OFS_MODE, 32'h0000_0004);
      bus(1'b0, `OFS_MODE, 32'h0000_0000);
      chk("ovf_cleared", 32'h0000_0004, q);
      bus(1'b1, `OFS_MODE, 32'h0000_0000);
      $display("test overflow done");
    end
  endtask

  task t_clear;
    begin
      bus(1'b1, `OFS_CCA, 32'h0000_FF00);
      bus(1'b1, `OFS_CAPT, 32'h0000_0004);
      bus(1'b1, `OFS_PRES, 32'h0000_0048);
      bus(1'b1, `OFS_MODE, 32'h0000_000A);
      watch(20);
      src.pulse(1'b0, 1);
      watch(10);
      chk("glitch_irq_b", 32'h0000_0000, nb);
      src.set_pin(1'b0, 1'b1);
      watch(10);
      chk("edge_irq_b", 32'h0000_0001, nb);
      chk("edge_toggle", 32'h0000_0001, nt);
      chk("edge_irq_a", 32'h0000_0000, na);
      bus(1'b0, `OFS_CCB, 32'h0000_0000);
      v = q;
      chk("ccb_loaded", 32'h0000_0001, v > 32'h0000_0010);
      bus(1'b0, `OFS_COUNT, 32'h0000_0000);
      chk("count_cleared", 32'h0000_0001, q < v);
      bus(1'b1, `OFS_MODE, 32'h0000_0000);
      src.set_pin(1'b0, 1'b0);
      $display("test clear and start done");
    end
  endtask

  task t_reverse;
    begin
      bus(1'b1, `OFS_CAPT, 32'h0000_0003);
      bus(1'b1, `OFS_PRES, 32'h0000_0028);
      bus(1'b1, `OFS_MODE, 32'h0000_0008);
      src.set_pin(1'b0, 1'b1);
      watch(20);
      src.set_pin(1'b0, 1'b0);
      watch(10);
      chk("reverse_irq_a", 32'h0000_0000, na);
      bus(1'b0, `OFS_CCA, 32'h0000_0000);
      v = q;
      chk("cca_captured", 32'h0000_0001, v > 32'h0000_0010);
      src.set_pin(1'b1, 1'b1);
      watch(10);
      chk("sec_irq_a", 32'h0000_0001, na);
      bus(1'b0, `OFS_CCA, 32'h0000_0000);
      chk("cca_kept", v, q);
      bus(1'b1, `OFS_MODE, 32'h0000_0000);
      src.set_pin(1'b1, 1'b0);
      $display("test reverse phase done");
    end
  endtask

  // The toggle output is left unjudged while secondary edges are live.
  task t_both_cap;
    begin
      bus(1'b1, `OFS_CCB, 32'h0000_1234);
      bus(1'b1, `OFS_CAPT, 32'h0000_0005);
      bus(1'b1, `OFS_PRES, 32'h0000_0070);
      bus(1'b1, `OFS_MODE, 32'h0000_0004);
      watch(10);
      src.set_pin(1'b1, 1'b1);
      watch(10);
      chk("sec_rise_irq_a", 32'h0000_0001, na);
      src.set_pin(1'b1, 1'b0);
      watch(10);
      chk("sec_fall_irq_a", 32'h0000_0001, na);
      chk("sec_irq_b", 32'h0000_0000, nb);
      bus(1'b0, `OFS_CCA, 32'h0000_0000);
      chk("cca_loaded", 32'h0000_0001, q > 32'h0000_0010);
      bus(1'b0, `OFS_CCB, 32'h0000_0000);
      chk("ccb_untouched", 32'h0000_1234, q);
      bus(1'b1, `OFS_MODE, 32'h0000_0000);
      $display("test both capture done");
    end
  endtask

  // Divide-by-four count clock, falling primary edge, stop code 11 and
  // the output disable, none of which the other scenarios reach.
  task t_slow;
    begin
      bus(1'b1, `OFS_CAPT, 32'h0000_0004);
      bus(1'b1, `OFS_PRES, 32'h0000_0001);
      bus(1'b1, `OFS_MODE, 32'h0000_0004);
      src.set_pin(1'b0, 1'b1);
      watch(40);
      chk("rise_ignored", 32'h0000_0000, nb);
      src.set_pin(1'b0, 1'b0);
      watch(10);
      chk("fall_irq_b", 32'h0000_0001, nb);
      bus(1'b0, `OFS_CCB, 32'h0000_0000);
      chk("ccb_div4", 32'h0000_0001, q[31:4] == 28'h000_0000 && q[3]);
      bus(1'b1, `OFS_MODE, 32'h0000_000C);
      bus(1'b0, `OFS_COUNT, 32'h0000_0000);
      chk("stop_code_11", 32'h0000_0000, q);
      bus(1'b1, `OFS_OUTC, 32'h0000_0000);
      watch(2);
      chk("out_forced_low", 32'h0000_0000, toggle_output);
      $display("test slow clock done");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 12 cycles, then every scenario in turn.
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'b0011;
    wb_dat_i = 32'h0000_0000;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_free_cmp;
    t_ovf;
    t_clear;
    t_reverse;
    t_both_cap;
    t_slow;
    final_report;
  end

  // Watchdog sized well past the overflow scan, the longest scenario.
  initial begin
    #340000;
    err_count = err_count + 1;
    final_report;
  end
endmodule
